// *** rtl/gdl_pkg.sv ***
// Constants, states and field layout shared by both ends of the gamma register link.
// Assumes a single 25 MHz ref_clk per end and a pulled-up two-wire bus.
// Summary of operation
// - Channel A..L at address bytes 0..11
// - Address 00h then data 06h resets device
// - Code 00001xxx at <=400kHz enters high speed
// - Channel writes load only the staging bank
// - Bit 15 set copies whole staging bank out
// - Copy happens after final data bit arrives
// - Load strobe pin updates outputs from staging
// - Master stages twelve, then rewrites one with bit15
// - Each channel resets to its own code
// - Twelve addressable channel registers, one output each
// - Strobe low follows writes; high holds outputs
// - General call and power-up update outputs always
// - Upper nibble ignored; only channels 0..11 acknowledged
// - Bus address 74h or 75h by select pin
package gdl_pkg;
  localparam int GDL_CHANNELS = 12;
  localparam int GDL_CODE_W = 10;
  localparam logic [3:0] GDL_LAST_CHANNEL = 4'hB;
  localparam logic [6:0] GDL_DEV_ADDR_LOW = 7'h74;
  localparam logic [6:0] GDL_DEV_ADDR_HIGH = 7'h75;
  localparam logic [7:0] GDL_GCALL_ADDR = 8'h00;
  localparam logic [7:0] GDL_GCALL_RESET = 8'h06;
  localparam logic [4:0] GDL_HS_PREFIX = 5'h01;
  localparam int GDL_TRIGGER_BIT = 15;
  localparam int GDL_TRIGGER_MSB_BIT = GDL_TRIGGER_BIT - 8;
  // Power-up codes, index 11 (channel L) first
  localparam logic [11:0][9:0] GDL_RESET_CODES = {
    10'h040, 10'h0A0, 10'h100, 10'h160, 10'h1C0, 10'h200,
    10'h240, 10'h280, 10'h2C0, 10'h320, 10'h380, 10'h3C0};
  localparam int GDL_REF_CLK_NS = 40;
  localparam int GDL_SCL_MIN_PERIOD_NS = 2500;
  localparam int GDL_SCL_QUARTER_CYC =
    (GDL_SCL_MIN_PERIOD_NS / 4 + GDL_REF_CLK_NS - 1) / GDL_REF_CLK_NS;
  localparam logic [11:0] GDL_HOST_CMD_OFS = 12'h000;
  localparam logic [11:0] GDL_HOST_STATUS_OFS = 12'h004;
  localparam logic [11:0] GDL_HOST_PINS_OFS = 12'h008;
  localparam int GDL_CMD_START_BIT = 8;
  localparam int GDL_CMD_STOP_BIT = 9;
  localparam int GDL_CMD_READ_BIT = 10;
  localparam int GDL_CMD_NACK_BIT = 11;
  localparam int GDL_STAT_BUSY_BIT = 0;
  localparam int GDL_STAT_NACK_BIT = 1;
  localparam int GDL_STAT_HS_BIT = 2;
  typedef enum logic [7:0] {
    GDL_D_IDLE = 8'b0000_0001,
    GDL_D_DEVADDR = 8'b0000_0010,
    GDL_D_CHAN = 8'b0000_0100,
    GDL_D_WMSB = 8'b0000_1000,
    GDL_D_WLSB = 8'b0001_0000,
    GDL_D_RDATA = 8'b0010_0000,
    GDL_D_GCALL = 8'b0100_0000,
    GDL_D_IGNORE = 8'b1000_0000
  } gdl_dev_state_t;
  typedef enum logic [3:0] {
    GDL_H_IDLE = 4'b0001,
    GDL_H_START = 4'b0010,
    GDL_H_BIT = 4'b0100,
    GDL_H_STOP = 4'b1000
  } gdl_host_state_t;
endpackage : gdl_pkg

// *** rtl/gdl_if.sv ***
// Two-wire link plus load strobe between the bus master and the register latch.
// Open-drain wires resolve here with an implied pull-up.
`timescale 1ns/100ps
`default_nettype none
interface gdl_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic output_load_strobe;
  logic scl;
  logic sda;
  assign scl = host_scl_oe ? host_scl_o : 1'b1;
  assign sda = dev_sda_oe ? dev_sda_o : (host_sda_oe ? host_sda_o : 1'b1);
  modport device (input scl, input sda, input output_load_strobe,
                  output dev_sda_o, output dev_sda_oe);
  modport host (input sda, output host_scl_o, output host_scl_oe,
                output host_sda_o, output host_sda_oe, output output_load_strobe);
endinterface : gdl_if
`default_nettype wire

// *** rtl/gdl_dev.sv ***
// Two-wire slave with twelve double-buffered channel registers.
// Assumes link pins are asynchronous to ref_clk and SCL stays well below ref_clk/8.
`timescale 1ns/100ps
`default_nettype none
module gdl_dev
  import gdl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  gdl_if.device link,
  input wire logic bus_address_select_pin,
  output logic [11:0][9:0] channel_level,
  output logic hs_mode
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [2:0] ld_s;
    logic [2:0] sel_s;
    logic scl_f;
    logic sda_f;
    logic ld_f;
    logic sel_f;
    gdl_dev_state_t state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] msb;
    logic [3:0] ptr;
    logic mack;
    logic rd_lsb;
    logic sda_oe;
    logic hs;
    logic [11:0][9:0] bank;
    logic [11:0][9:0] outv;
  } gdl_dev_reg_t;

  gdl_dev_reg_t s;
  gdl_dev_reg_t next_s;

  function automatic logic [3:0] gdl_next_chan(input logic [3:0] p);
    gdl_next_chan = (p == GDL_LAST_CHANNEL) ? 4'h0 : p + 4'h1;
  endfunction : gdl_next_chan

  function automatic logic gdl_filter(input logic [2:0] sy, input logic cur);
    gdl_filter = (sy[2] == sy[1]) ? sy[2] : cur;
  endfunction : gdl_filter

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic scl_new;
    logic sda_new;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic [6:0] my_addr;
    logic [7:0] b;
    scl_new = 1'b0;
    sda_new = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    my_addr = 7'h00;
    b = 8'h00;
    next_s = s;
    next_s.scl_s = {s.scl_s[1:0], link.scl};
    next_s.sda_s = {s.sda_s[1:0], link.sda};
    next_s.ld_s = {s.ld_s[1:0], link.output_load_strobe};
    next_s.sel_s = {s.sel_s[1:0], bus_address_select_pin};
    scl_new = gdl_filter(s.scl_s, s.scl_f);
    sda_new = gdl_filter(s.sda_s, s.sda_f);
    next_s.scl_f = scl_new;
    next_s.sda_f = sda_new;
    next_s.ld_f = gdl_filter(s.ld_s, s.ld_f);
    next_s.sel_f = gdl_filter(s.sel_s, s.sel_f);
    rise = scl_new & ~s.scl_f;
    fall = ~scl_new & s.scl_f;
    start = s.scl_f & scl_new & s.sda_f & ~sda_new;
    stop = s.scl_f & scl_new & ~s.sda_f & sda_new;
    my_addr = s.sel_f ? GDL_DEV_ADDR_HIGH : GDL_DEV_ADDR_LOW;
    b = s.shreg;

    if (start) begin
      next_s.state = GDL_D_DEVADDR;
      next_s.bitcnt = 4'h0;
      next_s.sda_oe = 1'b0;
    end else if (stop) begin
      next_s.state = GDL_D_IDLE;
      next_s.sda_oe = 1'b0;
      next_s.hs = 1'b0;
    end else if (rise && s.state != GDL_D_IDLE) begin
      next_s.bitcnt = s.bitcnt + 4'h1;
      if (s.bitcnt < 4'h8) begin
        next_s.shreg = {s.shreg[6:0], sda_new};
      end else begin
        next_s.mack = ~sda_new;
      end
    end else if (fall && s.state != GDL_D_IDLE) begin
      if (s.bitcnt == 4'h8) begin
        next_s.sda_oe = 1'b0;
        unique case (s.state)
          GDL_D_DEVADDR: begin
            if (b[7:1] == my_addr) begin
              next_s.sda_oe = 1'b1;
              next_s.state = b[0] ? GDL_D_RDATA : GDL_D_CHAN;
              next_s.mack = 1'b1;
              next_s.rd_lsb = 1'b0;
            end else if (b == GDL_GCALL_ADDR) begin
              next_s.sda_oe = 1'b1;
              next_s.state = GDL_D_GCALL;
            end else if (b[7:3] == GDL_HS_PREFIX) begin
              next_s.hs = 1'b1;
              next_s.state = GDL_D_IGNORE;
            end else begin
              next_s.state = GDL_D_IGNORE;
            end
          end
          GDL_D_CHAN: begin
            if (b[3:0] <= GDL_LAST_CHANNEL) begin
              next_s.ptr = b[3:0];
              next_s.sda_oe = 1'b1;
              next_s.state = GDL_D_WMSB;
            end else begin
              next_s.state = GDL_D_IGNORE;
            end
          end
          GDL_D_WMSB: begin
            next_s.msb = b;
            next_s.sda_oe = 1'b1;
            next_s.state = GDL_D_WLSB;
          end
          GDL_D_WLSB: begin
            next_s.sda_oe = 1'b1;
            next_s.bank[s.ptr] = {s.msb[1:0], b};
            if (s.msb[GDL_TRIGGER_MSB_BIT]) begin
              next_s.outv = next_s.bank;
            end
            next_s.ptr = gdl_next_chan(s.ptr);
            next_s.state = GDL_D_WMSB;
          end
          GDL_D_GCALL: begin
            if (b == GDL_GCALL_RESET) begin
              next_s.sda_oe = 1'b1;
              next_s.bank = GDL_RESET_CODES;
              next_s.outv = GDL_RESET_CODES;
              next_s.hs = 1'b0;
            end
            next_s.state = GDL_D_IGNORE;
          end
          GDL_D_RDATA: begin
            next_s.sda_oe = 1'b0;
          end
          default: begin
            next_s.sda_oe = 1'b0;
          end
        endcase
      end else if (s.bitcnt == 4'h9) begin
        next_s.bitcnt = 4'h0;
        next_s.sda_oe = 1'b0;
        if (s.state == GDL_D_RDATA) begin
          if (s.mack) begin
            // Read streams MSB then LSB of each channel, then steps on
            if (!s.rd_lsb) begin
              next_s.shreg = {6'h00, s.bank[s.ptr][9:8]};
            end else begin
              next_s.shreg = s.bank[s.ptr][7:0];
              next_s.ptr = gdl_next_chan(s.ptr);
            end
            next_s.rd_lsb = ~s.rd_lsb;
            next_s.sda_oe = ~next_s.shreg[7];
          end else begin
            next_s.state = GDL_D_IGNORE;
          end
        end
      end else if (s.state == GDL_D_RDATA) begin
        next_s.sda_oe = ~s.shreg[7];
      end
    end

    if (!s.ld_f) begin
      next_s.outv = next_s.bank;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s <= '0;
      s.scl_s <= 3'h7;
      s.sda_s <= 3'h7;
      s.scl_f <= 1'b1;
      s.sda_f <= 1'b1;
      s.state <= GDL_D_IDLE;
      s.bank <= GDL_RESET_CODES;
      s.outv <= GDL_RESET_CODES;
    end else begin
      s <= next_s;
    end
  end

  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = s.sda_oe;
  assign channel_level = s.outv;
  assign hs_mode = s.hs;
endmodule : gdl_dev
`default_nettype wire

// *** rtl/gdl_host.sv ***
// Bus master end: byte-level two-wire engine driven over APB by software.
// Assumes sda arrives asynchronously; SCL is made here by a divider from ref_clk.
`timescale 1ns/100ps
`default_nettype none
module gdl_host
  import gdl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  gdl_if.host link
);
  typedef struct packed {
    logic [2:0] sda_s;
    logic sda_f;
    gdl_host_state_t state;
    logic [4:0] qcnt;
    logic [1:0] phase;
    logic [3:0] bitcnt;
    logic [7:0] tx;
    logic [7:0] rx;
    logic do_stop;
    logic do_read;
    logic send_nack;
    logic nack_seen;
    logic hs_sent;
    logic scl_oe;
    logic sda_oe;
    logic ld;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } gdl_host_reg_t;

  gdl_host_reg_t s;
  gdl_host_reg_t next_s;

  localparam logic [4:0] GDL_QTOP = 5'(GDL_SCL_QUARTER_CYC - 1);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic tick;
    logic wr;
    tick = 1'b0;
    wr = 1'b0;
    next_s = s;
    next_s.sda_s = {s.sda_s[1:0], link.sda};
    next_s.sda_f = (s.sda_s[2] == s.sda_s[1]) ? s.sda_s[2] : s.sda_f;
    // APB: answer ready one cycle after setup, write lands at the access edge
    next_s.pready = psel & ~penable;
    next_s.pslverr = 1'b0;
    if (psel && !penable) begin
      next_s.prdata = 32'h0000_0000;
      if (paddr == GDL_HOST_STATUS_OFS) begin
        next_s.prdata[15:8] = s.rx;
        next_s.prdata[GDL_STAT_BUSY_BIT] = (s.state != GDL_H_IDLE);
        next_s.prdata[GDL_STAT_NACK_BIT] = s.nack_seen;
        next_s.prdata[GDL_STAT_HS_BIT] = s.hs_sent;
      end else if (paddr == GDL_HOST_PINS_OFS) begin
        next_s.prdata[0] = s.ld;
      end else if (paddr != GDL_HOST_CMD_OFS) begin
        next_s.pslverr = 1'b1;
      end
    end
    wr = psel & penable & s.pready & pwrite;
    if (wr && paddr == GDL_HOST_PINS_OFS) begin
      next_s.ld = pwdata[0];
    end
    if (wr && paddr == GDL_HOST_CMD_OFS && s.state == GDL_H_IDLE) begin
      next_s.tx = pwdata[7:0];
      next_s.do_stop = pwdata[GDL_CMD_STOP_BIT];
      next_s.do_read = pwdata[GDL_CMD_READ_BIT];
      next_s.send_nack = pwdata[GDL_CMD_NACK_BIT];
      next_s.hs_sent = pwdata[GDL_CMD_START_BIT] & (pwdata[7:3] == GDL_HS_PREFIX);
      next_s.state = pwdata[GDL_CMD_START_BIT] ? GDL_H_START : GDL_H_BIT;
      next_s.phase = 2'h0;
      next_s.bitcnt = 4'h0;
      next_s.qcnt = GDL_QTOP;
    end else if (s.state != GDL_H_IDLE) begin
      // Quarter-period divider keeps SCL at or below the 400kHz rate
      tick = (s.qcnt == 5'h00);
      next_s.qcnt = tick ? GDL_QTOP : s.qcnt - 5'h01;
      if (tick) begin
        next_s.phase = s.phase + 2'h1;
        unique case (s.state)
          GDL_H_START: begin
            unique case (s.phase)
              2'h0: next_s.sda_oe = 1'b0;
              2'h1: next_s.scl_oe = 1'b0;
              2'h2: next_s.sda_oe = 1'b1;
              2'h3: begin
                next_s.scl_oe = 1'b1;
                next_s.state = GDL_H_BIT;
              end
            endcase
          end
          GDL_H_BIT: begin
            unique case (s.phase)
              2'h0: begin
                if (s.bitcnt < 4'h8) begin
                  next_s.sda_oe = s.do_read ? 1'b0 : ~s.tx[7];
                end else begin
                  next_s.sda_oe = s.do_read ? ~s.send_nack : 1'b0;
                end
              end
              2'h1: next_s.scl_oe = 1'b0;
              2'h2: next_s.scl_oe = 1'b0;
              2'h3: begin
                next_s.scl_oe = 1'b1;
                next_s.bitcnt = s.bitcnt + 4'h1;
                if (s.bitcnt < 4'h8) begin
                  next_s.rx = {s.rx[6:0], s.sda_f};
                  next_s.tx = {s.tx[6:0], 1'b0};
                end else begin
                  if (!s.do_read) begin
                    next_s.nack_seen = s.sda_f;
                  end
                  next_s.state = s.do_stop ? GDL_H_STOP : GDL_H_IDLE;
                end
              end
            endcase
          end
          GDL_H_STOP: begin
            unique case (s.phase)
              2'h0: next_s.sda_oe = 1'b1;
              2'h1: next_s.scl_oe = 1'b0;
              2'h2: next_s.sda_oe = 1'b0;
              2'h3: next_s.state = GDL_H_IDLE;
            endcase
          end
          default: next_s.state = GDL_H_IDLE;
        endcase
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s <= '0;
      s.sda_s <= 3'h7;
      s.sda_f <= 1'b1;
      s.state <= GDL_H_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign link.host_scl_o = 1'b0;
  assign link.host_scl_oe = s.scl_oe;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = s.sda_oe;
  assign link.output_load_strobe = s.ld;
endmodule : gdl_host
`default_nettype wire

// *** bench/gdl_props.sv ***
// Concurrent checks on the two-wire link and the channel outputs.
// Assumes one ref_clk domain and the resolved wires of gdl_if.
`timescale 1ns/100ps
`default_nettype none
module gdl_props import gdl_pkg::*; (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe,
  input wire logic output_load_strobe,
  input wire logic [11:0][9:0] channel_level,
  input wire logic hs_mode
);
  // ****************
  // Link and outputs
  // ****************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_reset_codes:
    assert property ($rose(reset_n) |-> channel_level == GDL_RESET_CODES)
    else $error("outputs not at power-up codes");
  a_strobe_hold:
    assert property ((output_load_strobe && scl) [*8] |-> $stable(channel_level))
    else $error("outputs moved while strobe held high");
  a_scl_low_min:
    assert property ($fell(scl) |-> (!scl) [*8])
    else $error("serial clock low phase too short");
  a_dev_drive_low:
    assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("device took data line while clock high");
  a_dev_ack_hold:
    assert property ($rose(dev_sda_oe) |-> dev_sda_oe [*8])
    else $error("device released data line early");
  a_dev_stable_high:
    assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("device data changed while clock high");
  a_hs_stop_clear:
    assert property (scl && $past(scl) && $rose(sda) |-> ##[1:12] !hs_mode)
    else $error("high-speed flag survived a stop");
  a_hs_no_ack:
    assert property ($rose(hs_mode) |-> !dev_sda_oe)
    else $error("device acknowledged master code");
endmodule : gdl_props
`default_nettype wire

// *** bench/tb.sv ***
// Testbench joining host and device ends through gdl_if, driven over APB.
// Assumes the package constants and a 25 MHz ref_clk.
`timescale 1ns/100ps
`default_nettype none
module tb import gdl_pkg::*; ;
  localparam logic [7:0] adr_low = {GDL_DEV_ADDR_LOW, 1'b0};
  localparam logic [7:0] adr_high = {GDL_DEV_ADDR_HIGH, 1'b0};
  logic ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, sel_pin, hs_mode;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [11:0][9:0] level, stage, shown;
  int errors, checked;
  gdl_if link ();
  gdl_host i_gdl_host (.ref_clk(ref_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link.host));
  gdl_dev i_gdl_dev (.ref_clk(ref_clk), .reset_n(reset_n), .link(link.device),
    .bus_address_select_pin(sel_pin), .channel_level(level), .hs_mode(hs_mode));
  gdl_props i_gdl_props (.ref_clk(ref_clk), .reset_n(reset_n), .scl(link.scl), .sda(link.sda),
    .dev_sda_oe(link.dev_sda_oe), .output_load_strobe(link.output_load_strobe),
    .channel_level(level), .hs_mode(hs_mode));
  always #20 ref_clk = ~ref_clk;
  // ****************
  // Bus tasks
  // ****************
  task automatic check(input logic [119:0] seen, input logic [119:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic cmd(input logic [11:0] c, output logic [31:0] st);
    logic e;
    apb(1'b1, GDL_HOST_CMD_OFS, {20'h0, c}, st, e);
    do begin
      apb(1'b0, GDL_HOST_STATUS_OFS, 32'h0, st, e);
    end while (st[GDL_STAT_BUSY_BIT] !== 1'b0);
  endtask : cmd
  task automatic pins(input logic v);
    logic [31:0] r;
    logic e;
    apb(1'b1, GDL_HOST_PINS_OFS, {31'h0, v}, r, e);
    repeat (8) @(posedge ref_clk);
  endtask : pins
  task automatic wr(input logic [7:0] adr, input logic [7:0] ch, input logic [15:0] v);
    logic [31:0] st;
    cmd({4'h1, adr}, st);
    check(120'(st[GDL_STAT_NACK_BIT]), 120'(1'b0));
    cmd({4'h0, ch}, st);
    cmd({4'h0, v[15:8]}, st);
    cmd({4'h2, v[7:0]}, st);
  endtask : wr
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset;
    logic [31:0] r;
    logic e;
    check(level, GDL_RESET_CODES);
    apb(1'b0, GDL_HOST_PINS_OFS, 32'h0, r, e);
    check(120'(r), 120'(0));
    apb(1'b0, 12'h0FC, 32'h0, r, e);
    check(120'(e), 120'(1'b1));
    $display("t_reset done");
  endtask : t_reset
  task automatic t_follow;
    wr(adr_low, 8'h0B, 16'h03FF);
    stage[11] = 10'h3FF;
    shown = stage;
    check(level, shown);
    $display("t_follow done");
  endtask : t_follow
  task automatic t_stage;
    logic [31:0] st;
    logic e;
    pins(1'b1);
    apb(1'b0, GDL_HOST_PINS_OFS, 32'h0, st, e);
    check(120'(st[0]), 120'(1'b1));
    cmd({4'h1, adr_low}, st);
    cmd(12'h000, st);
    for (int i = 0; i < GDL_CHANNELS; i++) begin
      stage[i] = 10'(i * 77 + 9);
      cmd({4'h0, 6'h00, stage[i][9:8]}, st);
      cmd({(i == GDL_CHANNELS - 1) ? 4'h2 : 4'h0, stage[i][7:0]}, st);
    end
    check(level, shown);
    cmd({4'h1, adr_low}, st);
    cmd(12'h005, st);
    cmd({4'h0, 6'h20, stage[5][9:8]}, st);
    check(level, shown);
    cmd({4'h2, stage[5][7:0]}, st);
    repeat (8) @(posedge ref_clk);
    shown = stage;
    check(level, shown);
    $display("t_stage done");
  endtask : t_stage
  task automatic t_strobe;
    wr(adr_low, 8'h02, 16'h0123);
    stage[2] = 10'h123;
    check(level, shown);
    pins(1'b0);
    shown = stage;
    check(level, shown);
    $display("t_strobe done");
  endtask : t_strobe
  task automatic t_addr;
    logic [31:0] st;
    wr(adr_low, 8'hF3, 16'h0077);
    stage[3] = 10'h077;
    shown = stage;
    check(level, shown);
    cmd({4'h1, adr_low}, st);
    cmd(12'h20C, st);
    check(120'(st[GDL_STAT_NACK_BIT]), 120'(1'b1));
    cmd({4'h3, adr_high}, st);
    check(120'(st[GDL_STAT_NACK_BIT]), 120'(1'b1));
    sel_pin <= 1'b1;
    repeat (8) @(posedge ref_clk);
    wr(adr_high, 8'h07, 16'h0200);
    stage[7] = 10'h200;
    shown = stage;
    check(level, shown);
    sel_pin <= 1'b0;
    repeat (8) @(posedge ref_clk);
    $display("t_addr done");
  endtask : t_addr
  task automatic t_gcall;
    logic [31:0] st;
    pins(1'b1);
    cmd({4'h1, GDL_GCALL_ADDR}, st);
    check(120'(st[GDL_STAT_NACK_BIT]), 120'(1'b0));
    cmd({4'h2, GDL_GCALL_RESET}, st);
    repeat (8) @(posedge ref_clk);
    stage = GDL_RESET_CODES;
    shown = stage;
    check(level, shown);
    pins(1'b0);
    $display("t_gcall done");
  endtask : t_gcall
  task automatic t_hs;
    logic [31:0] st;
    cmd({4'h1, GDL_HS_PREFIX, 3'h5}, st);
    check(120'(st[GDL_STAT_HS_BIT]), 120'(1'b1));
    check(120'(hs_mode), 120'(1'b1));
    cmd({4'h3, adr_low}, st);
    check(120'(hs_mode), 120'(1'b0));
    $display("t_hs done");
  endtask : t_hs
  task automatic t_read;
    logic [31:0] st;
    cmd({4'h1, adr_low}, st);
    cmd(12'h000, st);
    cmd({4'h1, adr_low | 8'h01}, st);
    check(120'(st[GDL_STAT_NACK_BIT]), 120'(1'b0));
    cmd(12'h400, st);
    check(120'(st[15:8]), 120'({6'h00, stage[0][9:8]}));
    cmd(12'hE00, st);
    check(120'(st[15:8]), 120'(stage[0][7:0]));
    $display("t_read done");
  endtask : t_read
  task automatic summarize;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  initial begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sel_pin = 1'b0;
    stage = GDL_RESET_CODES;
    shown = stage;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_reset;
    t_follow;
    t_stage;
    t_strobe;
    t_addr;
    t_gcall;
    t_hs;
    t_read;
    summarize;
  end
  initial begin
    repeat (90000) @(posedge ref_clk);
    errors++;
    summarize;
  end
endmodule : tb
`default_nettype wire
